//--- include/ihp_pkg.sv
// Shared constants and types for the indirect host register port
package ihp_pkg;

    // External location map
    localparam logic [2:0] DATA_LOWEST_OFS   = 3'h0;
    localparam logic [2:0] DATA_SECOND_OFS   = 3'h1;
    localparam logic [2:0] DATA_THIRD_OFS    = 3'h2;
    localparam logic [2:0] DATA_HIGHEST_OFS  = 3'h3;
    localparam logic [2:0] SLEEP_LOAD_OFS    = 3'h4;
    localparam logic [2:0] SYNC_TRIGGER_OFS  = 3'h5;
    localparam logic [2:0] LOW_ADDR_OFS      = 3'h6;
    localparam logic [2:0] UPPER_ADDR_OFS    = 3'h7;

    // Field positions
    localparam int UPPER_WR_INC_BIT   = 7;
    localparam int UPPER_RD_INC_BIT   = 6;
    localparam int SYNC_BEAM_BIT      = 6;
    localparam int SYNC_HOP_BIT       = 5;
    localparam int SYNC_START_BIT     = 4;
    localparam int SLEEP_PROG_LSB     = 4;
    localparam int NUM_CHANNELS       = 4;

    // Widths
    localparam int EXT_ADDR_W = 3;
    localparam int EXT_DATA_W = 8;
    localparam int INT_ADDR_W = 12;
    localparam int INT_DATA_W = 32;

    // Reset values
    localparam logic [7:0]  SLEEP_LOAD_RST = 8'h00;
    localparam logic [7:0]  LOW_ADDR_RST   = 8'h00;
    localparam logic [7:0]  UPPER_ADDR_RST = 8'h00;
    localparam logic [31:0] DATA_RST       = 32'h0000_0000;

    // Internal access length
    localparam int INT_ACCESS_CYCLES = 2;

    // Access sequencer, Gray coded along the usual path
    typedef enum logic [1:0] {
        IHP_IDLE = 2'b00,
        IHP_ACC1 = 2'b01,
        IHP_ACC2 = 2'b11,
        IHP_DONE = 2'b10
    } ihp_state_t;

    typedef struct packed {
        logic                  rd;
        logic                  wr;
        logic [INT_ADDR_W-1:0] addr;
        logic [INT_DATA_W-1:0] wdata;
    } ihp_int_req_t;

    typedef struct packed {
        logic [NUM_CHANNELS-1:0] beam;
        logic [NUM_CHANNELS-1:0] hop;
        logic [NUM_CHANNELS-1:0] start;
    } ihp_sync_t;

endpackage : ihp_pkg

//--- rtl/ihp_port.sv
// Indirect host register port: external registers, access sequencer, handshake
// Summary of operation
// R1 - Eight external byte locations via 3-bit address and 8-bit data bus.
// R2 - Indirect space uses 12-bit address and 32-bit data words.
// R3 - Location 7 bits 3:0 hold upper four internal address bits.
// R4 - Location 6 holds lower eight internal address bits.
// R5 - Upper bit 6 set: increment address after each internal read.
// R6 - Upper bit 7 set: increment address after each internal write.
// R7 - Locations 0..3 form data word, 0 least significant byte.
// R8 - Write to location 0 starts internal write; higher bytes first.
// R9 - Read of location 0 starts internal read, loads all bytes.
// R10 - Host writes both address registers before triggering an access.
// R11 - Each internal access lasts two clock cycles.
// R12 - Locations 4 and 5 act directly, no indirect trigger.
// R13 - Location 5 write-only: beam, hop, start types and channel selects.
// R14 - One sync write issues every selected type to every selected channel.
// R15 - Host not using software sync writes sync register all low.
// R16 - Location 4 bits 7:4 are per-channel program enables.
// R17 - Location 4 bits 3:0 are per-channel sleep; high brings channel up.
// R18 - Start sync events clear selected sleep bits.
// R19 - Strapped mode: low separate strobes with wait, high data strobe.
// R20 - Separate-strobe mode: wait low at indirect access start until internal cycle completes.
// R21 - Data-strobe mode: acknowledge low at completion until strobe released.
// R22 - Wait/acknowledge output is open drain.
// R23 - Multiple accesses allowed while chip select stays low.
`timescale 1ns/1ps

module ihp_port (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_mode,
    input  wire logic                  i_cs_n,
    input  wire logic                  i_rd_ds_n,
    input  wire logic                  i_wr_rw,
    input  wire logic [2:0]            i_addr,
    input  wire logic [7:0]            i_data,
    output logic      [7:0]            o_data,
    output logic                       o_data_oe,
    output logic                       o_ack_out,
    output logic                       o_ack_oe,
    output ihp_pkg::ihp_int_req_t      o_int_req,
    input  wire logic [31:0]           i_int_rdata,
    input  wire logic [3:0]            i_pin_start,
    output logic      [3:0]            o_channel_awake,
    output logic      [3:0]            o_prog_enable,
    output ihp_pkg::ihp_sync_t         o_sync
);

    // Reset release through two flops
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Strap capture after reset release
    logic mode_q;
    logic strap_done_q;

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            strap_done_q <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
        end
    end

    // Mode pin read once after each reset release, then frozen until the next reset
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= 1'b0;
        end else if (!strap_done_q) begin
            mode_q <= i_mode; // R19
        end
    end

    // Strobe decode per handshake style
    logic strobe_on;
    logic is_read;

    always_comb begin
        if (mode_q) begin
            strobe_on = !i_cs_n && !i_rd_ds_n; // R19
            is_read   = i_wr_rw;
        end else begin
            strobe_on = !i_cs_n && (!i_rd_ds_n || !i_wr_rw); // R19
            is_read   = !i_rd_ds_n;
        end
    end

    ihp_pkg::ihp_state_t state_q;
    ihp_pkg::ihp_state_t state_d;
    logic                acc_rd_q;

    logic start_acc;
    logic indirect;
    logic finish;

    assign start_acc = (state_q == ihp_pkg::IHP_IDLE) && strap_done_q && strobe_on;
    assign indirect  = (i_addr == ihp_pkg::DATA_LOWEST_OFS); // R8 R9
    assign finish    = (state_q == ihp_pkg::IHP_ACC2);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ihp_pkg::IHP_IDLE: begin
                if (start_acc) begin
                    state_d = indirect ? ihp_pkg::IHP_ACC1 : ihp_pkg::IHP_DONE; // R12
                end
            end
            ihp_pkg::IHP_ACC1: begin
                state_d = ihp_pkg::IHP_ACC2; // R11
            end
            ihp_pkg::IHP_ACC2: begin
                state_d = ihp_pkg::IHP_DONE;
            end
            ihp_pkg::IHP_DONE: begin
                if (!strobe_on) begin
                    state_d = ihp_pkg::IHP_IDLE; // R23
                end
            end
            default: begin
                state_d = ihp_pkg::IHP_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ihp_pkg::IHP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Direction of the access in flight, kept for its completion
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            acc_rd_q <= 1'b0;
        end else if (start_acc) begin
            acc_rd_q <= is_read;
        end
    end

    // Address registers with auto increment
    logic [7:0]  low_addr_q;
    logic [7:0]  upper_q;
    logic [11:0] int_addr;
    logic [11:0] int_addr_inc;
    logic        do_inc;

    assign int_addr     = {upper_q[3:0], low_addr_q}; // R2 R3 R4
    assign int_addr_inc = int_addr + 12'h001;
    assign do_inc       = finish && (acc_rd_q ? upper_q[ihp_pkg::UPPER_RD_INC_BIT] // R5
                                              : upper_q[ihp_pkg::UPPER_WR_INC_BIT]); // R6

    logic host_wr;
    assign host_wr = start_acc && !is_read;

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            low_addr_q <= ihp_pkg::LOW_ADDR_RST;
        end else if (do_inc) begin
            low_addr_q <= int_addr_inc[7:0]; // R5 R6
        end else if (host_wr && (i_addr == ihp_pkg::LOW_ADDR_OFS)) begin
            low_addr_q <= i_data; // R4
        end
    end

    // Increment enables kept; bits 5:4 read back as zero
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            upper_q <= ihp_pkg::UPPER_ADDR_RST;
        end else if (do_inc) begin
            upper_q <= {upper_q[7:4], int_addr_inc[11:8]};
        end else if (host_wr && (i_addr == ihp_pkg::UPPER_ADDR_OFS)) begin
            upper_q <= {i_data[7:6], 2'b00, i_data[3:0]}; // R3
        end
    end

    // Data window, one byte lane per location
    logic [31:0] data_q;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_byte
            always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    data_q[gb*8 +: 8] <= ihp_pkg::DATA_RST[gb*8 +: 8];
                end else if (finish && acc_rd_q) begin
                    data_q[gb*8 +: 8] <= i_int_rdata[gb*8 +: 8]; // R9
                end else if (host_wr && (i_addr == 3'(gb))) begin
                    data_q[gb*8 +: 8] <= i_data; // R7
                end
            end
        end
    endgenerate

    // Internal access strobes, held for both access cycles
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_int_req.rd <= 1'b0;
            o_int_req.wr <= 1'b0;
        end else if (start_acc && indirect) begin
            o_int_req.rd <= is_read; // R9
            o_int_req.wr <= !is_read; // R8
        end else if (finish) begin
            o_int_req.rd <= 1'b0; // R11
            o_int_req.wr <= 1'b0;
        end
    end

    // Address and word captured at the trigger
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_int_req.addr  <= '0;
            o_int_req.wdata <= '0;
        end else if (start_acc && indirect) begin
            o_int_req.addr  <= int_addr; // R2
            o_int_req.wdata <= {data_q[31:8], i_data}; // R7 R8
        end
    end

    // Per-channel sleep, program enable and sync
    logic [3:0] sleep_bit_q;
    logic [3:0] prog_bit_q;
    logic       sleep_wr;
    logic       sync_wr;
    logic       beam_req;
    logic       hop_req;
    logic       start_req;

    assign sleep_wr  = host_wr && (i_addr == ihp_pkg::SLEEP_LOAD_OFS); // R12
    assign sync_wr   = host_wr && (i_addr == ihp_pkg::SYNC_TRIGGER_OFS); // R12
    assign beam_req  = sync_wr && i_data[ihp_pkg::SYNC_BEAM_BIT]; // R13
    assign hop_req   = sync_wr && i_data[ihp_pkg::SYNC_HOP_BIT]; // R13
    assign start_req = sync_wr && i_data[ihp_pkg::SYNC_START_BIT]; // R13

    genvar gc;
    generate
        for (gc = 0; gc < ihp_pkg::NUM_CHANNELS; gc++) begin : g_chan
            logic start_clr;
            assign start_clr = i_pin_start[gc] || (start_req && i_data[gc]); // R18

            // A host write wins over a start clear in the same cycle
            always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    sleep_bit_q[gc] <= ihp_pkg::SLEEP_LOAD_RST[gc];
                end else if (sleep_wr) begin
                    sleep_bit_q[gc] <= i_data[gc]; // R17
                end else if (start_clr) begin
                    sleep_bit_q[gc] <= 1'b0; // R18
                end
            end

            always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    prog_bit_q[gc] <= ihp_pkg::SLEEP_LOAD_RST[ihp_pkg::SLEEP_PROG_LSB + gc];
                end else if (sleep_wr) begin
                    prog_bit_q[gc] <= i_data[ihp_pkg::SLEEP_PROG_LSB + gc]; // R16
                end
            end

            // Levels to the channel
            always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    o_channel_awake[gc] <= 1'b0;
                    o_prog_enable[gc]   <= 1'b0;
                end else begin
                    o_channel_awake[gc] <= sleep_bit_q[gc]; // R17
                    o_prog_enable[gc]   <= prog_bit_q[gc]; // R16
                end
            end

            // One-cycle pulses, any mix of types and channels
            always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    o_sync.beam[gc]  <= 1'b0;
                    o_sync.hop[gc]   <= 1'b0;
                    o_sync.start[gc] <= 1'b0;
                end else begin
                    o_sync.beam[gc]  <= beam_req && i_data[gc]; // R14
                    o_sync.hop[gc]   <= hop_req && i_data[gc]; // R14
                    o_sync.start[gc] <= start_req && i_data[gc]; // R14
                end
            end
        end
    endgenerate

    // Read data mux
    logic [7:0] rd_byte;

    always_comb begin
        case (i_addr)
            ihp_pkg::DATA_LOWEST_OFS: begin
                rd_byte = data_q[7:0];
            end
            ihp_pkg::DATA_SECOND_OFS: begin
                rd_byte = data_q[15:8];
            end
            ihp_pkg::DATA_THIRD_OFS: begin
                rd_byte = data_q[23:16];
            end
            ihp_pkg::DATA_HIGHEST_OFS: begin
                rd_byte = data_q[31:24];
            end
            ihp_pkg::SLEEP_LOAD_OFS: begin
                rd_byte = {prog_bit_q, sleep_bit_q};
            end
            ihp_pkg::SYNC_TRIGGER_OFS: begin
                rd_byte = 8'h00; // R13
            end
            ihp_pkg::LOW_ADDR_OFS: begin
                rd_byte = low_addr_q;
            end
            ihp_pkg::UPPER_ADDR_OFS: begin
                rd_byte = upper_q;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_data <= 8'h00;
        end else if (finish && acc_rd_q) begin
            o_data <= i_int_rdata[7:0]; // R9
        end else if (start_acc && is_read && !indirect) begin
            o_data <= rd_byte; // R12
        end
    end

    // Bus driven from the taken read until its strobe is released
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_data_oe <= 1'b0;
        end else if (start_acc && is_read) begin
            o_data_oe <= 1'b1; // R1
        end else if (!strobe_on) begin
            o_data_oe <= 1'b0;
        end
    end

    // Open-drain wait/acknowledge: pin only ever pulled low
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_ack_out <= 1'b0;
        end else begin
            o_ack_out <= 1'b0; // R22
        end
    end

    // Pin pulled low: wait during access, or acknowledge after it
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_ack_oe <= 1'b0;
        end else if (!mode_q) begin
            if (start_acc && indirect) begin
                o_ack_oe <= 1'b1; // R20
            end else if (finish) begin
                o_ack_oe <= 1'b0; // R20
            end
        end else if (finish || (start_acc && !indirect)) begin
            o_ack_oe <= 1'b1; // R21
        end else if (!strobe_on) begin
            o_ack_oe <= 1'b0; // R21
        end
    end

endmodule : ihp_port

//--- tb/ihp_port_chk.sv
// Assertion checker for the indirect host register port
`timescale 1ns/1ps

module ihp_port_chk (
    input wire logic                  i_ref_clk,
    input wire logic                  i_nrst,
    input wire logic                  i_mode,
    input wire logic                  i_rd_ds_n,
    input wire logic                  o_ack_out,
    input wire logic                  o_ack_oe,
    input wire ihp_pkg::ihp_int_req_t o_int_req,
    input wire ihp_pkg::ihp_sync_t    o_sync
);
    logic acc;
    assign acc = o_int_req.rd | o_int_req.wr;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    wr_len_a: assert property ($rose(o_int_req.wr) |-> o_int_req.wr[*2] ##1 !o_int_req.wr)
        else $error("internal write not two cycles");
    rd_len_a: assert property ($rose(o_int_req.rd) |-> o_int_req.rd[*2] ##1 !o_int_req.rd)
        else $error("internal read not two cycles");
    rd_wr_excl_a: assert property (!(o_int_req.rd && o_int_req.wr))
        else $error("read and write together");
    drain_low_a: assert property (o_ack_out == 1'b0)
        else $error("handshake pin driven high");
    wait_hold_a: assert property (!i_mode && acc |-> o_ack_oe)
        else $error("wait missing during access");
    wait_free_a: assert property (!i_mode && $fell(acc) |-> !o_ack_oe)
        else $error("wait not released");
    ack_done_a: assert property (i_mode && $fell(acc) |-> o_ack_oe)
        else $error("ack missing at completion");
    ack_drop_a: assert property (i_mode && o_ack_oe && i_rd_ds_n |-> ##[1:2] !o_ack_oe)
        else $error("ack not returned high");
    sync_pulse_a: assert property (|o_sync |=> !(|o_sync))
        else $error("sync pulse too long");

    cover property ($rose(o_int_req.wr));
    cover property ($rose(o_int_req.rd));
    cover property (|o_sync);
endmodule : ihp_port_chk

bind ihp_port ihp_port_chk u_chk (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_mode(i_mode), .i_rd_ds_n(i_rd_ds_n),
    .o_ack_out(o_ack_out), .o_ack_oe(o_ack_oe), .o_int_req(o_int_req), .o_sync(o_sync)
);

//--- tb/ihp_mem_model.sv
// Internal register space model behind the port
`timescale 1ns/1ps

module ihp_mem_model (
    input  wire logic                  i_clk,
    input  wire ihp_pkg::ihp_int_req_t i_req,
    output logic [31:0]                o_rdata
);
    logic [31:0] mem [0:4095];
    logic [11:0] last_addr;
    logic [31:0] last_wdata = 32'h0000_0000;
    always @(posedge i_clk) begin
        if (i_req.wr) begin
            mem[i_req.addr] <= i_req.wdata;
            last_addr       <= i_req.addr;
            last_wdata      <= i_req.wdata;
        end
    end
    // Idle bus shows inverted junk
    assign o_rdata = i_req.rd ? mem[i_req.addr] : ~last_wdata;
endmodule : ihp_mem_model

//--- tb/indirect_host_register_port_tb.sv
// Self-checking bench for the indirect host register port
`timescale 1ns/1ps

module indirect_host_register_port_tb;
    logic                  clk = 0, i_nrst = 0, i_mode = 0, i_cs_n = 1, i_rd_ds_n = 1, i_wr_rw = 1;
    logic [2:0]            i_addr = 3'h0;
    logic [7:0]            i_data = 8'h00, o_data, q;
    logic                  o_data_oe, o_ack_out, o_ack_oe;
    logic [3:0]            i_pin_start = 4'h0, awake, prog;
    logic [31:0]           rdata;
    ihp_pkg::ihp_int_req_t req;
    ihp_pkg::ihp_sync_t    sync, seen;
    int                    failures = 0, samples_checked = 0, cyc = 0;

    ihp_port dut (.i_ref_clk(clk), .i_nrst(i_nrst), .i_mode(i_mode), .i_cs_n(i_cs_n),
        .i_rd_ds_n(i_rd_ds_n), .i_wr_rw(i_wr_rw), .i_addr(i_addr), .i_data(i_data), .o_data(o_data),
        .o_data_oe(o_data_oe), .o_ack_out(o_ack_out), .o_ack_oe(o_ack_oe), .o_int_req(req),
        .i_int_rdata(rdata), .i_pin_start(i_pin_start), .o_channel_awake(awake),
        .o_prog_enable(prog), .o_sync(sync));
    ihp_mem_model mdl (.i_clk(clk), .i_req(req), .o_rdata(rdata));

    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        seen <= seen | sync;
        cyc  <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic rst(input logic m);
        i_nrst = 0;
        i_mode = m;
        repeat (2) @(negedge clk);
        i_nrst = 1;
        repeat (4) @(negedge clk);
    endtask : rst

    // One host access; strobe held until wait released or ack seen
    task automatic acc(input logic [2:0] a, input logic rd, input logic [7:0] wd);
        int n;
        n = 0;
        i_addr = a;
        i_data = wd;
        i_cs_n = 0;
        i_wr_rw = rd;
        i_rd_ds_n = i_mode ? 1'b0 : !rd;
        @(negedge clk);
        do begin
            @(negedge clk);
            n++;
        end while (o_ack_oe !== i_mode && n < 10);
        if (n >= 10) failures++;
        q = o_data;
        chk(o_data_oe, rd);
        i_rd_ds_n = 1;
        i_wr_rw = 1;
        repeat (2) @(negedge clk);
    endtask : acc

    task automatic t_window;
        acc(3'h7, 0, 8'hC1); acc(3'h6, 0, 8'hFE);
        acc(3'h3, 0, 8'h44); acc(3'h2, 0, 8'h33); acc(3'h1, 0, 8'h22); acc(3'h0, 0, 8'h11);
        chk(mdl.last_addr, 12'h1FE);
        chk(mdl.last_wdata, 32'h4433_2211);
        acc(3'h6, 1, 0); chk(q, 8'hFF);
        acc(3'h7, 1, 0); chk(q, 8'hC1);
        acc(3'h6, 0, 8'hFE);
        acc(3'h0, 1, 0); chk(q, 8'h11);
        acc(3'h6, 1, 0); chk(q, 8'hFF);
        acc(3'h3, 1, 0); chk(q, 8'h44);
        acc(3'h2, 1, 0); chk(q, 8'h33);
        acc(3'h1, 1, 0); chk(q, 8'h22);
        acc(3'h7, 0, 8'h81); acc(3'h6, 0, 8'hFE); acc(3'h0, 1, 0);
        acc(3'h6, 1, 0); chk(q, 8'hFE);
        $display("window test done");
    endtask : t_window

    task automatic t_sync;
        seen = '0; acc(3'h5, 0, 8'h14); chk(seen, 12'h004);
        seen = '0; acc(3'h5, 0, 8'h6F); chk(seen, 12'hFF0);
        acc(3'h5, 1, 0); chk(q, 8'h00);
        seen = '0; acc(3'h5, 0, 8'h00); chk(seen, 12'h000);
        $display("sync test done");
    endtask : t_sync

    task automatic t_sleep;
        acc(3'h4, 0, 8'hA5);
        chk(prog, 4'hA);
        chk(awake, 4'h5);
        acc(3'h4, 1, 0); chk(q, 8'hA5);
        acc(3'h5, 0, 8'h11); chk(awake, 4'h4);
        i_pin_start = 4'h4;
        @(negedge clk);
        i_pin_start = 4'h0;
        repeat (2) @(negedge clk);
        chk(awake, 4'h0);
        $display("sleep test done");
    endtask : t_sleep

    task automatic t_strobe;
        rst(1);
        acc(3'h6, 0, 8'h10); acc(3'h7, 0, 8'h02); acc(3'h1, 0, 8'hBE); acc(3'h0, 0, 8'hEF);
        chk(mdl.last_addr, 12'h210);
        chk(mdl.last_wdata, 32'h0000_BEEF);
        acc(3'h0, 1, 0); chk(q, 8'hEF);
        acc(3'h1, 1, 0); chk(q, 8'hBE);
        $display("strobe mode test done");
    endtask : t_strobe

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    initial begin
        seen = '0;
        rst(0);
        t_window();
        t_sync();
        t_sleep();
        t_strobe();
        conclude();
    end
endmodule : indirect_host_register_port_tb
